//--- logic/dmacp_defs.vh
// Register map, field positions, codes and reset values of the paging channel
`ifndef DMACP_DEFS_VH
`define DMACP_DEFS_VH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DMACP_IDX_PRI      4'h0
`define DMACP_IDX_SEC      4'h1
`define DMACP_IDX_CNT      4'h2
`define DMACP_IDX_SRC      4'h3
`define DMACP_IDX_DST      4'h4
`define DMACP_IDX_GADDR_A  4'h5
`define DMACP_IDX_GADDR_B  4'h6
`define DMACP_IDX_GADDR_C  4'h7
`define DMACP_IDX_GADDR_D  4'h8
`define DMACP_IDX_GCNT_A   4'h9
`define DMACP_IDX_GCNT_B   4'ha
`define DMACP_IDX_IRQ_STAT 4'hb
`define DMACP_IDX_IRQ_MASK 4'hc

// ----------------------------------------------------------------
// Primary control fields
// ----------------------------------------------------------------
`define DMACP_PRI_START    1:0
`define DMACP_PRI_STATUS   3:2
`define DMACP_PRI_ORIGIN_STEP_MODE  5:4
`define DMACP_PRI_TARGET_STEP_MODE  7:6
`define DMACP_PRI_ELEMENT_WIDTH    9:8
`define DMACP_PRI_CNT_SEL  11
`define DMACP_PRI_RSEL     18:14
`define DMACP_PRI_TRANSFER_IRQ_ENABLE    25
`define DMACP_PRI_FS       26
`define DMACP_PRI_EMULATION_HALT_MODE     27
`define DMACP_PRI_SRC_REL  29:28
`define DMACP_PRI_DST_REL  31:30
`define DMACP_PRI_WMASK    32'hfeffcff3
`define DMACP_PRI_RESET    32'h00000000

// ----------------------------------------------------------------
// Secondary control fields (condition k at 2+2k, enable at 3+2k)
// ----------------------------------------------------------------
`define DMACP_NCOND        4
`define DMACP_COND_FRAME   0
`define DMACP_COND_LAST    1
`define DMACP_COND_BLOCK   2
`define DMACP_COND_RDROP   3
`define DMACP_SEC_RSTAT    12
`define DMACP_SEC_RCLR     13

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define DMACP_START_RUN    2'b01
`define DMACP_STAT_STOP    2'b00
`define DMACP_STAT_RUN     2'b01
`define DMACP_DIR_INC      2'b01
`define DMACP_DIR_DEC      2'b10
`define DMACP_ESZ_WORD     2'b00
`define DMACP_ESZ_HALF     2'b01
`define DMACP_RSEL_EXT6    5'h06
`define DMACP_WORD_STEP    32'h00000004
`define DMACP_HALF_STEP    32'h00000002
`define DMACP_BYTE_STEP    32'h00000001

`endif

//--- logic/dmacp_pm_arbiter.v
// Program memory arbiter: core always wins within its own memory block
`timescale 1ns/1ns
module dmacp_pm_arbiter #(
  parameter NBLK      = 2,
  parameter BLK_SHIFT = 16
) (
  // Channel side
  input  wire            chan_req,
  input  wire [31:0]     chan_addr,
  // Core requests per block
  input  wire [NBLK-1:0] core_req,
  // Grant to channel
  output wire            grant
);
  localparam BW = (NBLK > 1) ? $clog2(NBLK) : 1;

  wire [NBLK-1:0] blk_busy;  // Core holds the block channel targets

  // ------------------------------------------------------------
  // Per block contention check
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NBLK; i = i + 1)
    begin : g_blk
      localparam [BW-1:0] IDX = i;
      // Only the block that is addressed can stall the channel
      assign blk_busy[i] = core_req[i] &&
        (chan_addr[BLK_SHIFT+BW-1:BLK_SHIFT] == IDX);
    end
  endgenerate

  // Core first on conflict
  assign grant = chan_req && !(|blk_busy);
endmodule

//--- logic/dmacp_channel.v
// Code paging DMA channel with Avalon-MM register slave
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "dmacp_defs.vh"
module dmacp_channel #(
  parameter NBLK      = 2,
  parameter BLK_SHIFT = 16
) (
  // Clock and reset
  input  wire            mclk,
  input  wire            reset,
  // Avalon-MM slave
  input  wire [3:0]      avs_address,
  input  wire            avs_read,
  input  wire            avs_write,
  input  wire [31:0]     avs_writedata,
  input  wire [3:0]      avs_byteenable,
  output reg  [31:0]     avs_readdata,
  output reg             avs_waitrequest,
  // Sync pin and emulation halt
  input  wire            external_event_line_six,
  input  wire            emu_halt,
  // External memory read port
  output reg             ext_rd_req,
  output reg  [31:0]     ext_rd_addr,
  input  wire            ext_rd_ack,
  input  wire [31:0]     ext_rd_data,
  // Program memory write port
  input  wire [NBLK-1:0] core_pm_req,
  output reg             pm_wr_en,
  output reg  [31:0]     pm_wr_addr,
  output reg  [31:0]     pm_wr_data,
  output reg  [3:0]      pm_wr_be,
  // Interrupt
  output reg             channel_irq_line
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'd0;  // Waiting for work
  localparam [1:0] ST_READ  = 2'd1;  // Source read in flight
  localparam [1:0] ST_WRITE = 2'd2;  // Waiting for grant
  localparam [1:0] ST_DONE  = 2'd3;  // Write committed
  localparam NC = `DMACP_NCOND;

  reg  [1:0]    state_reg;           // Engine state
  reg  [31:0]   pri_reg;             // Primary control
  reg  [NC-1:0] cond_reg;            // Condition flags
  reg  [NC-1:0] ie_reg;              // Condition enables
  reg  [NC-1:0] en_cond_reg;         // Enabled flags, last cycle
  reg           pend_reg;            // Read sync pending
  reg  [31:0]   cnt_reg;             // Frame and element counts
  reg  [31:0]   src_reg;             // Source address
  reg  [31:0]   dst_reg;             // Destination address
  reg  [31:0]   gaddr_reg [0:3];     // Global addresses A..D
  reg  [31:0]   gcnt_reg  [0:1];     // Global count reloads A, B
  reg  [NC-1:0] irq_stat_reg;        // Sticky interrupt status
  reg  [NC-1:0] irq_mask_reg;        // Interrupt mask
  reg           frame_busy_reg;      // Frame in progress
  reg  [31:0]   data_reg;            // Element in flight
  reg  [2:0]    pin_sync_reg;        // Pin synchroniser, edge
  wire          acc_done;            // Bus access completes now
  wire          wr_done;             // Write completes now
  wire          rd_done;             // Read completes now
  wire [31:0]   bmask;               // Byte enable bit mask
  wire          grant;               // Program memory grant
  wire          run;                 // Channel started
  wire          halted;              // Held by emulation halt
  wire          sw_sync;             // Software sync request
  wire          pin_sync;            // Pin sync request
  wire          sync_evt;            // Any read sync event
  wire          consume;             // Sync taken by engine
  wire          step_now;            // Element retired
  wire          frame_end;           // Last element of frame
  wire          block_end;           // Last element of block
  wire [NC-1:0] hw_set;              // Condition set pulses
  wire [NC-1:0] en_cond;             // Enabled conditions
  wire [NC-1:0] irq_rise;            // Rising enabled condition
  wire [1:0]    dir_src;
  wire [1:0]    dir_dst;
  wire [1:0]    esz;

  assign run     = pri_reg[`DMACP_PRI_START] == `DMACP_START_RUN;
  assign halted  = pri_reg[`DMACP_PRI_EMULATION_HALT_MODE] && emu_halt;
  assign dir_src = pri_reg[`DMACP_PRI_ORIGIN_STEP_MODE];
  assign dir_dst = pri_reg[`DMACP_PRI_TARGET_STEP_MODE];
  assign esz     = pri_reg[`DMACP_PRI_ELEMENT_WIDTH];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Apply byte enables to a register write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] m;
    begin
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // Post-element address update by element size
  function [31:0] step_addr;
    input [31:0] a;
    input [1:0]  dir;
    input [1:0]  w;
    reg   [31:0] s;
    begin
      s = (w == `DMACP_ESZ_WORD) ? `DMACP_WORD_STEP :
          (w == `DMACP_ESZ_HALF) ? `DMACP_HALF_STEP :
          `DMACP_BYTE_STEP;
      case (dir)
        `DMACP_DIR_INC: step_addr = a + s;
        `DMACP_DIR_DEC: step_addr = a - s;
        default:        step_addr = a;
      endcase
    end
  endfunction

  // Byte lanes of one element
  function [3:0] lanes;
    input [1:0] a;
    input [1:0] w;
    begin
      case (w)
        `DMACP_ESZ_WORD: lanes = 4'hf;
        `DMACP_ESZ_HALF: lanes = a[1] ? 4'hc : 4'h3;
        default:         lanes = 4'h1 << a;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Avalon-MM slave handshake
  // ------------------------------------------------------------
  assign acc_done = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_done  = acc_done && avs_write;
  assign rd_done  = acc_done && avs_read;
  assign bmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // One wait cycle, then one ready cycle per access
  always @(posedge mclk)
  begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
      avs_waitrequest <= 1'b0;
  end

  // Read data latched as the access is answered
  always @(posedge mclk)
  begin
    if (reset)
      avs_readdata <= 32'h00000000;
    else if (avs_read && avs_waitrequest)
    begin
      case (avs_address)
        `DMACP_IDX_PRI:
          avs_readdata <= {pri_reg[31:4],
            (run ? `DMACP_STAT_RUN : `DMACP_STAT_STOP),
            pri_reg[1:0]};
        `DMACP_IDX_SEC:
          avs_readdata <= sec_view(cond_reg, ie_reg, pend_reg);
        `DMACP_IDX_CNT:      avs_readdata <= cnt_reg;
        `DMACP_IDX_SRC:      avs_readdata <= src_reg;
        `DMACP_IDX_DST:      avs_readdata <= dst_reg;
        `DMACP_IDX_GADDR_A:  avs_readdata <= gaddr_reg[0];
        `DMACP_IDX_GADDR_B:  avs_readdata <= gaddr_reg[1];
        `DMACP_IDX_GADDR_C:  avs_readdata <= gaddr_reg[2];
        `DMACP_IDX_GADDR_D:  avs_readdata <= gaddr_reg[3];
        `DMACP_IDX_GCNT_A:   avs_readdata <= gcnt_reg[0];
        `DMACP_IDX_GCNT_B:   avs_readdata <= gcnt_reg[1];
        `DMACP_IDX_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_reg};
        `DMACP_IDX_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_reg};
        default:             avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Secondary control as software sees it
  function [31:0] sec_view;
    input [NC-1:0] c;
    input [NC-1:0] e;
    input          p;
    integer        k;
    begin
      sec_view = 32'h00000000;
      for (k = 0; k < NC; k = k + 1)
      begin
        sec_view[2+2*k] = c[k];
        sec_view[3+2*k] = e[k];
      end
      sec_view[`DMACP_SEC_RSTAT] = p;
    end
  endfunction

  // ------------------------------------------------------------
  // Control and global registers
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pri_reg      <= `DMACP_PRI_RESET;
      gaddr_reg[0] <= 32'h00000000;
      gaddr_reg[1] <= 32'h00000000;
      gaddr_reg[2] <= 32'h00000000;
      gaddr_reg[3] <= 32'h00000000;
      gcnt_reg[0]  <= 32'h00000000;
      gcnt_reg[1]  <= 32'h00000000;
      irq_mask_reg <= {NC{1'b0}};
    end
    else if (wr_done)
    begin
      case (avs_address)
        `DMACP_IDX_PRI: pri_reg <= merge(pri_reg, avs_writedata,
                                         bmask & `DMACP_PRI_WMASK);
        `DMACP_IDX_GADDR_A:
          gaddr_reg[0] <= merge(gaddr_reg[0], avs_writedata, bmask);
        `DMACP_IDX_GADDR_B:
          gaddr_reg[1] <= merge(gaddr_reg[1], avs_writedata, bmask);
        `DMACP_IDX_GADDR_C:
          gaddr_reg[2] <= merge(gaddr_reg[2], avs_writedata, bmask);
        `DMACP_IDX_GADDR_D:
          gaddr_reg[3] <= merge(gaddr_reg[3], avs_writedata, bmask);
        `DMACP_IDX_GCNT_A:
          gcnt_reg[0] <= merge(gcnt_reg[0], avs_writedata, bmask);
        `DMACP_IDX_GCNT_B:
          gcnt_reg[1] <= merge(gcnt_reg[1], avs_writedata, bmask);
        `DMACP_IDX_IRQ_MASK:
          irq_mask_reg <= avs_byteenable[0] ? avs_writedata[NC-1:0]
                                            : irq_mask_reg;
        default: ;  // Unmapped or handled elsewhere
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read synchronisation events
  // ------------------------------------------------------------
  // Two flops before use, third for edge detect
  always @(posedge mclk)
  begin
    if (reset)
      pin_sync_reg <= 3'b000;
    else
      pin_sync_reg <= {pin_sync_reg[1:0], external_event_line_six};
  end

  assign pin_sync = pin_sync_reg[1] && !pin_sync_reg[2] &&
                    pri_reg[`DMACP_PRI_RSEL] == `DMACP_RSEL_EXT6;
  assign sw_sync  = wr_done && avs_address == `DMACP_IDX_SEC &&
                    avs_byteenable[1] &&
                    avs_writedata[`DMACP_SEC_RSTAT];
  assign sync_evt = sw_sync || pin_sync;
  assign consume  = state_reg == ST_IDLE && run && !halted &&
                    !frame_busy_reg && pend_reg;

  // Pending bit: new event wins over any clear
  always @(posedge mclk)
  begin
    if (reset)
      pend_reg <= 1'b0;
    else if (sync_evt)
      pend_reg <= 1'b1;
    else if (consume || (wr_done && avs_address == `DMACP_IDX_SEC &&
             avs_byteenable[1] && avs_writedata[`DMACP_SEC_RCLR]))
      pend_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  assign step_now  = state_reg == ST_DONE;
  assign frame_end = step_now && cnt_reg[15:0] <= 16'h0001;
  assign block_end = frame_end && cnt_reg[31:16] <= 16'h0001;

  dmacp_pm_arbiter #(
    .NBLK      (NBLK),
    .BLK_SHIFT (BLK_SHIFT)
  ) u_arb (
    .chan_req  (state_reg == ST_WRITE),
    .chan_addr (dst_reg),
    .core_req  (core_pm_req),
    .grant     (grant)
  );

  // Element sequencer: read source, write program memory
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg      <= ST_IDLE;
      frame_busy_reg <= 1'b0;
      ext_rd_req     <= 1'b0;
      ext_rd_addr    <= 32'h00000000;
      data_reg       <= 32'h00000000;
      pm_wr_en       <= 1'b0;
      pm_wr_addr     <= 32'h00000000;
      pm_wr_data     <= 32'h00000000;
      pm_wr_be       <= 4'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Frame sync keeps going until frame end
          if (run && !halted && (frame_busy_reg || pend_reg))
          begin
            frame_busy_reg <= pri_reg[`DMACP_PRI_FS];
            ext_rd_req     <= 1'b1;
            ext_rd_addr    <= src_reg;
            state_reg      <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (ext_rd_ack)
          begin
            ext_rd_req <= 1'b0;
            data_reg   <= ext_rd_data;
            state_reg  <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          // Stalls while the core holds this block
          if (grant)
          begin
            pm_wr_en   <= 1'b1;
            pm_wr_addr <= dst_reg;
            pm_wr_data <= data_reg;
            pm_wr_be   <= lanes(dst_reg[1:0], esz);
            state_reg  <= ST_DONE;
          end
        end
        default:
        begin
          // Write retired; element bookkeeping
          pm_wr_en  <= 1'b0;
          state_reg <= ST_IDLE;
          if (frame_end)
            frame_busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Addresses and counter: engine update wins over software
  always @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_reg <= 32'h00000000;
      src_reg <= 32'h00000000;
      dst_reg <= 32'h00000000;
    end
    else if (block_end)
    begin
      src_reg <= (pri_reg[`DMACP_PRI_SRC_REL] == 2'b00) ?
        step_addr(src_reg, dir_src, esz) :
        gaddr_reg[pri_reg[`DMACP_PRI_SRC_REL]];
      dst_reg <= (pri_reg[`DMACP_PRI_DST_REL] == 2'b00) ?
        step_addr(dst_reg, dir_dst, esz) :
        gaddr_reg[pri_reg[`DMACP_PRI_DST_REL]];
      cnt_reg <= gcnt_reg[pri_reg[`DMACP_PRI_CNT_SEL]];
    end
    else if (step_now)
    begin
      src_reg <= step_addr(src_reg, dir_src, esz);
      dst_reg <= step_addr(dst_reg, dir_dst, esz);
      if (frame_end)
        cnt_reg <= {cnt_reg[31:16] - 16'h0001,
          gcnt_reg[pri_reg[`DMACP_PRI_CNT_SEL]][15:0]};
      else
        cnt_reg <= {cnt_reg[31:16], cnt_reg[15:0] - 16'h0001};
    end
    else if (wr_done)
    begin
      case (avs_address)
        `DMACP_IDX_CNT: cnt_reg <= merge(cnt_reg, avs_writedata, bmask);
        `DMACP_IDX_SRC: src_reg <= merge(src_reg, avs_writedata, bmask);
        `DMACP_IDX_DST: dst_reg <= merge(dst_reg, avs_writedata, bmask);
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conditions and interrupt
  // ------------------------------------------------------------
  assign hw_set[`DMACP_COND_FRAME] = frame_end;
  assign hw_set[`DMACP_COND_LAST]  = frame_end &&
                                     cnt_reg[31:16] == 16'h0002;
  assign hw_set[`DMACP_COND_BLOCK] = block_end;
  assign hw_set[`DMACP_COND_RDROP] = sync_evt && pend_reg && !consume;

  genvar k;
  generate
    for (k = 0; k < NC; k = k + 1)
    begin : g_cond
      // Software writes 0 to clear; a same-cycle set wins
      always @(posedge mclk)
      begin
        if (reset)
        begin
          cond_reg[k] <= 1'b0;
          ie_reg[k]   <= 1'b0;
        end
        else
        begin
          if (hw_set[k])
            cond_reg[k] <= 1'b1;
          else if (wr_done && avs_address == `DMACP_IDX_SEC &&
                   avs_byteenable[(2+2*k)/8] && !avs_writedata[2+2*k])
            cond_reg[k] <= 1'b0;
          if (wr_done && avs_address == `DMACP_IDX_SEC &&
              avs_byteenable[(3+2*k)/8])
            ie_reg[k] <= avs_writedata[3+2*k];
        end
      end

      assign en_cond[k]  = cond_reg[k] && ie_reg[k];
      // Only a 0-to-1 change of an enabled flag interrupts
      assign irq_rise[k] = en_cond[k] && !en_cond_reg[k] &&
                           pri_reg[`DMACP_PRI_TRANSFER_IRQ_ENABLE];

      // Sticky status, cleared by reading it, set wins
      always @(posedge mclk)
      begin
        if (reset)
        begin
          en_cond_reg[k]  <= 1'b0;
          irq_stat_reg[k] <= 1'b0;
        end
        else
        begin
          en_cond_reg[k] <= en_cond[k];
          if (irq_rise[k])
            irq_stat_reg[k] <= 1'b1;
          else if (rd_done && avs_address == `DMACP_IDX_IRQ_STAT)
            irq_stat_reg[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level interrupt while an unmasked status bit stands
  always @(posedge mclk)
  begin
    if (reset)
      channel_irq_line <= 1'b0;
    else
      channel_irq_line <= |(irq_stat_reg & irq_mask_reg);
  end
endmodule

//--- test/dmacp_monitor.sv
// Checker of the paging channel's port behaviour
`timescale 1ns/1ns
`include "dmacp_defs.vh"
module dmacp_monitor #(
  parameter NBLK      = 2,
  parameter BLK_SHIFT = 16
) (
  // Clock and reset
  input wire            mclk,
  input wire            reset,
  // Register bus
  input wire [3:0]      avs_address,
  input wire            avs_read,
  input wire            avs_write,
  input wire [31:0]     avs_writedata,
  input wire            avs_waitrequest,
  // Memory ports
  input wire            ext_rd_req,
  input wire [31:0]     ext_rd_addr,
  input wire            ext_rd_ack,
  input wire [31:0]     ext_rd_data,
  input wire [NBLK-1:0] core_pm_req,
  input wire            pm_wr_en,
  input wire [31:0]     pm_wr_addr,
  input wire [31:0]     pm_wr_data,
  // Interrupt
  input wire            channel_irq_line
);
  reg [NBLK-1:0] core_q; // Core busy one cycle back
  reg [31:0]     ack_q;  // Last word from memory
  // Status read or mask write accepted
  wire clr_irq = !avs_waitrequest && (avs_read &&
    avs_address == `DMACP_IDX_IRQ_STAT || avs_write &&
    avs_address == `DMACP_IDX_IRQ_MASK);
  // Keep grant context and fetched word
  always @(posedge mclk)
  begin
    core_q <= core_pm_req;
    if (ext_rd_ack)
      ack_q <= ext_rd_data;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_acc;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_sync;
    avs_write && !avs_waitrequest && avs_address == `DMACP_IDX_SEC
    && avs_writedata[`DMACP_SEC_RSTAT];
  endsequence
  property p_wait_one;
    s_acc |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  property p_rd_hold;
    ext_rd_req && !ext_rd_ack |=> ext_rd_req && $stable(ext_rd_addr);
  endproperty
  property p_core_first;
    pm_wr_en |-> !core_q[pm_wr_addr[BLK_SHIFT]];
  endproperty
  property p_pass;
    pm_wr_en |-> pm_wr_data == ack_q;
  endproperty
  property p_gap;
    pm_wr_en |=> !pm_wr_en [*3];
  endproperty
  property p_irq_rise;
    $rose(channel_irq_line) |-> $past(pm_wr_en, 3);
  endproperty
  property p_irq_fall;
    $fell(channel_irq_line) |-> $past(clr_irq, 2);
  endproperty
  property p_sync;
    s_sync |-> ##[1:8] ext_rd_req;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not one cycle");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read request dropped early");
  a_core_first: assert property (p_core_first)
    else $error("write while core busy");
  a_pass: assert property (p_pass)
    else $error("written word differs");
  a_gap: assert property (p_gap)
    else $error("elements too close");
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt not after final write");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell unprompted");
  a_sync: assert property (p_sync)
    else $error("pending bit did not start frame");
endmodule
bind dmacp_channel dmacp_monitor #(
  .NBLK(NBLK),
  .BLK_SHIFT(BLK_SHIFT)
) i_dmacp_monitor (.*);

//--- test/dmacp_mem_model.sv
// External memory and core model for the paging channel
`timescale 1ns/1ns
module dmacp_mem_model #(
  parameter [31:0] KEY = 32'h5a5aa5a5
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        ext_rd_req,
  input  wire [31:0] ext_rd_addr,
  output reg         ext_rd_ack,
  output reg  [31:0] ext_rd_data,
  input  wire [1:0]  core_busy,
  output wire [1:0]  core_pm_req
);
  reg [1:0] wait_cnt; // Latency, varies with address
  assign core_pm_req = core_busy;
  // Answer after 1..4 cycles; idle data toggles
  always @(posedge mclk)
    if (reset || !ext_rd_req || ext_rd_ack)
    begin
      wait_cnt    <= 2'h0;
      ext_rd_ack  <= 1'b0;
      ext_rd_data <= reset ? 32'h0 : ~ext_rd_data;
    end
    else if (wait_cnt == ext_rd_addr[3:2])
    begin
      ext_rd_ack  <= 1'b1;
      ext_rd_data <= ext_rd_addr ^ KEY;
    end
    else
    begin
      wait_cnt    <= wait_cnt + 2'h1;
      ext_rd_data <= ~ext_rd_data;
    end
endmodule

//--- test/tb_top.sv
// Self-checking bench of the paging channel
`timescale 1ns/1ns
`include "dmacp_defs.vh"
`define CHK(g, e, m) begin total_checks = total_checks + 1; \
  if ((g) !== (e)) begin err_count = err_count + 1; \
  $display("mismatch %0t %s", $time, m); end end
module tb_top;
  localparam [31:0] KEY = 32'h5a5aa5a5;
  reg mclk = 0, reset = 1, avs_read = 0, avs_write = 0;
  reg external_event_line_six = 0, emu_halt = 0;
  reg  [3:0]  avs_address = 0, avs_byteenable = 4'hf;
  reg  [31:0] avs_writedata = 0, rd;
  reg  [1:0]  core_busy = 0;
  wire [31:0] avs_readdata, ext_rd_addr, ext_rd_data;
  wire [31:0] pm_wr_addr, pm_wr_data;
  wire [3:0]  pm_wr_be;
  wire [1:0]  core_pm_req;
  wire avs_waitrequest, ext_rd_req, ext_rd_ack;
  wire pm_wr_en, channel_irq_line;
  logic [31:0] wa[$], wd[$]; // Captured writes
  integer err_count = 0, total_checks = 0;
  dmacp_channel i_dmacp_channel (.*);
  dmacp_mem_model #(.KEY(KEY)) i_dmacp_mem_model (.*);
  always #5 mclk = ~mclk;
  // Record program memory writes
  always @(posedge mclk)
    if (pm_wr_en === 1'b1)
    begin
      wa.push_back(pm_wr_addr);
      wd.push_back(pm_wr_data);
      `CHK(pm_wr_be, 4'hf, "lanes")
    end
  // One register access, held until accepted
  task bus(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask
  // Wait for one page of four words and judge it
  task page(input [31:0] s, input [31:0] d);
    integer i;
  begin
    i = 0;
    while (wa.size() < 4 && i < 3000)
    begin
      @(posedge mclk);
      i = i + 1;
    end
    repeat (6) @(posedge mclk);
    `CHK(wa.size(), 4, "word count")
    for (i = 0; i < 4; i = i + 1)
    begin
      `CHK(wa[i], d + 4 * i, "dest addr")
      `CHK(wd[i], (s + 4 * i) ^ KEY, "data")
    end
    wa = {};
    wd = {};
  end
  endtask
  task t_regs;
  begin
    bus(1, `DMACP_IDX_PRI, 32'h0000000c);
    bus(0, `DMACP_IDX_PRI, 0);
    `CHK(rd, 32'h0, "status writable")
    bus(1, 4'hd, 32'hffffffff);
    bus(0, 4'hd, 0);
    `CHK(rd, 32'h0, "unmapped")
    $display("regs done");
  end
  endtask
  task t_page1;
  begin
    bus(1, `DMACP_IDX_SRC, 32'h20000000);
    bus(1, `DMACP_IDX_DST, 32'h00006000);
    bus(1, `DMACP_IDX_CNT, 32'h00010004);
    bus(1, `DMACP_IDX_GCNT_A, 32'h00010004);
    bus(1, `DMACP_IDX_GADDR_B, 32'h20004000);
    bus(1, `DMACP_IDX_GADDR_C, 32'h0000a000);
    bus(1, `DMACP_IDX_IRQ_MASK, 32'h4);
    bus(1, `DMACP_IDX_PRI, 32'h96000051);
    bus(1, `DMACP_IDX_SEC, 32'h00001080);
    page(32'h20000000, 32'h00006000);
    `CHK(channel_irq_line, 1'b1, "no irq")
    bus(0, `DMACP_IDX_SRC, 0);
    `CHK(rd, 32'h20004000, "origin_refill_select")
    bus(0, `DMACP_IDX_DST, 0);
    `CHK(rd, 32'h0000a000, "target_refill_select")
    bus(0, `DMACP_IDX_CNT, 0);
    `CHK(rd, 32'h00010004, "count reload")
    bus(0, `DMACP_IDX_SEC, 0);
    `CHK(rd[6], 1'b1, "block flag")
    bus(0, `DMACP_IDX_IRQ_STAT, 0);
    `CHK(rd, 32'h4, "status")
    repeat (3) @(posedge mclk);
    `CHK(channel_irq_line, 1'b0, "irq stuck")
    $display("page1 done");
  end
  endtask
  task t_page2;
  begin
    core_busy <= 2'b10;
    bus(1, `DMACP_IDX_GADDR_B, 32'h20008000);
    bus(1, `DMACP_IDX_GADDR_C, 32'h00006000);
    bus(1, `DMACP_IDX_SEC, 32'h000010c0);
    page(32'h20004000, 32'h0000a000);
    `CHK(channel_irq_line, 1'b0, "irq again")
    core_busy <= 2'b00;
    $display("page2 done");
  end
  endtask
  task t_page3;
  begin
    core_busy <= 2'b01;
    bus(1, `DMACP_IDX_SEC, 32'h00001080);
    repeat (30) @(posedge mclk);
    `CHK(wa.size(), 0, "core not first")
    core_busy <= 2'b00;
    page(32'h20008000, 32'h00006000);
    `CHK(channel_irq_line, 1'b1, "no irq")
    bus(0, `DMACP_IDX_IRQ_STAT, 0);
    `CHK(rd, 32'h4, "status")
    $display("page3 done");
  end
  endtask
  // Pin-selected read sync starts the next page
  task t_pin;
  begin
    bus(1, `DMACP_IDX_PRI, 32'h96018051);
    external_event_line_six <= 1'b1;
    repeat (4) @(posedge mclk);
    external_event_line_six <= 1'b0;
    page(32'h20008000, 32'h00006000);
    $display("pin done");
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_regs;
    t_page1;
    t_page2;
    t_page3;
    t_pin;
    print_verdict;
  end
  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule
